// ===== hdl/cafm_pkg.sv
// package: register map, field layout and codes of the acceptance filter
package cafm_pkg;

  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS = 3;
  localparam int NUM_SEL_FILTERS = 8;
  localparam int STD_W = 11;
  localparam int EXT_W = 18;
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 4;

  // byte offsets inside the slave window
  localparam logic [ADDR_W-1:0] FLT_STD_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] FLT_EXT_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] SEL_LO_OFS = 8'h80;
  localparam logic [ADDR_W-1:0] SEL_HI_OFS = 8'h84;
  localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h88;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h8C;
  localparam logic [ADDR_W-1:0] HITS_OFS = 8'h90;
  localparam logic [ADDR_W-1:0] HIT_CNT_OFS = 8'h94;
  localparam logic [ADDR_W-1:0] MSK_STD_BASE = 8'hA0;
  localparam logic [ADDR_W-1:0] MSK_EXT_BASE = 8'hB0;

  // regions of 16 words, picked by haddr[7:6]
  localparam logic [1:0] RGN_FLT_STD = 2'h0;
  localparam logic [1:0] RGN_FLT_EXT = 2'h1;
  localparam logic [1:0] RGN_MISC = 2'h2;

  // layout shared by filter and mask standard-id registers
  localparam int STD_LSB = 5;
  localparam int STD_MSB = 15;
  localparam int TYPE_BIT = 3;
  localparam int EXT_HI_MSB = 1;
  localparam logic [REG_W-1:0] STD_REG_WMASK = 16'hFFEB;

  localparam int STAT_HIT_BIT = 4;

  localparam logic [REG_W-1:0] SEL_RESET = 16'h0000;
  localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [REG_W-1:0] DATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CAFM_SEL_MASK0 = 2'b00,
    CAFM_SEL_MASK1 = 2'b01,
    CAFM_SEL_MASK2 = 2'b10,
    CAFM_SEL_NONE = 2'b11
  } cafm_sel_t;

endpackage : cafm_pkg

// ===== hdl/cafm_filter_cmp.sv
// one acceptance filter compared against one received identifier
`timescale 1ns/1ps
module cafm_filter_cmp
  import cafm_pkg::*;
(
  input wire logic [STD_W-1:0] flt_std,
  input wire logic [EXT_W-1:0] flt_ext,
  input wire logic flt_ext_enable,
  input wire logic [STD_W-1:0] msk_std,
  input wire logic [EXT_W-1:0] msk_ext,
  input wire logic type_match_mode,
  input wire logic [STD_W-1:0] msg_std,
  input wire logic [EXT_W-1:0] msg_ext,
  input wire logic msg_ide,
  output logic hit
);

  logic std_ok;
  logic ext_ok;
  logic type_ok;

  // a mask bit of one forces equality; zero makes it don't-care
  assign std_ok = ~|((flt_std ^ msg_std) & msk_std);
  assign ext_ok = ~|((flt_ext ^ msg_ext) & msk_ext);

  // type check only when the mask asks for it
  assign type_ok = !type_match_mode || (flt_ext_enable == msg_ide);

  // standard frames carry no extended bits, so only the sid is compared
  always_comb begin
    hit = std_ok && type_ok && (!msg_ide || ext_ok);
  end

endmodule : cafm_filter_cmp

// ===== hdl/cafm_hit_pick.sv
// picks the lowest-numbered hitting filter
`timescale 1ns/1ps
module cafm_hit_pick
  import cafm_pkg::*;
(
  input wire logic [NUM_FILTERS-1:0] hits,
  output logic any,
  output logic [IDX_W-1:0] index
);

  // lowest index wins so the outcome is stable when filters overlap
  always_comb begin
    index = '0;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (hits[i]) begin
        index = IDX_W'(i);
      end
    end
    any = |hits;
  end

endmodule : cafm_hit_pick

// ===== hdl/cafm_top.sv
// acceptance filter block with ahb-lite register slave
// Contract
// - sixteen filters, each with extended-low register
// - reference bits 15..0 map to extended id
// - set bit needs one, clear needs zero
// - two-bit mask selectors, filter 7 on top
// - selectors 00/01/10 masks, 11 none, reset 00
// - mask sid bits at 15..5, one compares
// - mask eid 17..16 at bits 1..0
// - mask bit 3 is type-match mode
// - mode one: frame type must match enable
// - mode zero: either frame type accepted
// - mask bits 4 and 2 read zero
// - filter holds sid, enable, eid 17..16
// - enable picks extended or standard frames
// - second mask register holds eid 15..0
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module cafm_top
  import cafm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_id_valid,
  input wire logic [STD_W-1:0] rx_std_id,
  input wire logic [EXT_W-1:0] rx_ext_id,
  input wire logic rx_ide,
  output logic match_valid,
  output logic match_hit,
  output logic [IDX_W-1:0] match_index,
  output logic [NUM_FILTERS-1:0] match_vector
);

  logic [REG_W-1:0] flt_std_reg [NUM_FILTERS];
  logic [REG_W-1:0] filter_ext_id_low_reg [NUM_FILTERS];
  logic [REG_W-1:0] mask_std_id_and_type_mode_reg [NUM_MASKS];
  logic [REG_W-1:0] mask_ext_id_low_reg [NUM_MASKS];
  logic [REG_W-1:0] filter_mask_select_0_7_reg;
  logic [REG_W-1:0] filter_mask_select_8_15_reg;
  logic [REG_W-1:0] enable_reg;
  logic [REG_W-1:0] hit_cnt_reg;

  logic [ADDR_W-1:0] addr_reg;
  logic wr_pend_reg;
  logic rd_wait_reg;
  logic [31:0] hrdata_reg;

  logic accept;
  logic wr_go;
  logic [1:0] wr_rgn;
  logic [IDX_W-1:0] wr_idx;
  logic [1:0] wr_midx;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rd_value;
  logic msk_slot_ok;
  logic wr_flt_std;
  logic wr_flt_ext;
  logic wr_msk_std;
  logic wr_msk_ext;
  logic wr_sel_lo;
  logic wr_sel_hi;
  logic wr_enable;
  logic wr_hit_cnt;
  logic rx_take;
  logic hit_seen;

  logic [NUM_FILTERS-1:0] hits;
  logic [NUM_FILTERS-1:0] hits_en;
  logic pick_any;
  logic [IDX_W-1:0] pick_idx;
  logic [2*NUM_FILTERS-1:0] sel_all;

  // ---------------- ahb-lite slave ----------------

  // ce low stalls the bus rather than dropping a transfer
  assign hreadyout = ce && !rd_wait_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  assign accept = ce && hsel && hready && htrans[1];
  assign wr_go = ce && wr_pend_reg;
  assign wr_rgn = addr_reg[7:6];
  assign wr_idx = addr_reg[5:2];
  assign wr_midx = addr_reg[3:2];
  assign wdata = hwdata[REG_W-1:0];

  // the mask slot check is shared by reads and writes to keep the two maps in step
  assign msk_slot_ok = addr_reg[3:2] != 2'h3;
  assign wr_flt_std = wr_go && wr_rgn == RGN_FLT_STD;
  assign wr_flt_ext = wr_go && wr_rgn == RGN_FLT_EXT;
  assign wr_msk_std = wr_go && addr_reg[7:4] == MSK_STD_BASE[7:4] &&
                      msk_slot_ok;
  assign wr_msk_ext = wr_go && addr_reg[7:4] == MSK_EXT_BASE[7:4] &&
                      msk_slot_ok;
  assign wr_sel_lo = wr_go && addr_reg == SEL_LO_OFS;
  assign wr_sel_hi = wr_go && addr_reg == SEL_HI_OFS;
  assign wr_enable = wr_go && addr_reg == ENABLE_OFS;
  assign wr_hit_cnt = wr_go && addr_reg == HIT_CNT_OFS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= '0;
    end else if (accept) begin
      addr_reg <= haddr[ADDR_W-1:0];
    end
  end

  // writes complete without wait states in their data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
    end else if (ce && hready) begin
      wr_pend_reg <= accept && hwrite;
    end
  end

  // reads take one wait state so hrdata comes from a flop and
  // always sees a write that ended on the previous edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_reg <= 1'b0;
    end else if (ce) begin
      rd_wait_reg <= accept && !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (ce && rd_wait_reg) begin
      hrdata_reg <= {16'h0000, rd_value};
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rd_value = '0;
    case (addr_reg[7:6])
      RGN_FLT_STD: rd_value = flt_std_reg[addr_reg[5:2]];
      RGN_FLT_EXT: rd_value = filter_ext_id_low_reg[addr_reg[5:2]];
      RGN_MISC: begin
        if (addr_reg == SEL_LO_OFS) begin
          rd_value = filter_mask_select_0_7_reg;
        end else if (addr_reg == SEL_HI_OFS) begin
          rd_value = filter_mask_select_8_15_reg;
        end else if (addr_reg == ENABLE_OFS) begin
          rd_value = enable_reg;
        end else if (addr_reg == STATUS_OFS) begin
          rd_value = REG_W'({match_hit, match_index});
        end else if (addr_reg == HITS_OFS) begin
          rd_value = match_vector;
        end else if (addr_reg == HIT_CNT_OFS) begin
          rd_value = hit_cnt_reg;
        end else if (addr_reg[7:4] == MSK_STD_BASE[7:4] &&
                     msk_slot_ok) begin
          rd_value = mask_std_id_and_type_mode_reg[addr_reg[3:2]]
                     & STD_REG_WMASK;
        end else if (addr_reg[7:4] == MSK_EXT_BASE[7:4] &&
                     msk_slot_ok) begin
          rd_value = mask_ext_id_low_reg[addr_reg[3:2]];
        end else begin
          rd_value = '0;
        end
      end
      default: rd_value = '0;
    endcase
  end

  // ---------------- register file ----------------

  // filter standard-id words: sid, enable bit, eid 17..16
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        flt_std_reg[i] <= DATA_RESET;
      end
    end else if (wr_flt_std) begin
      flt_std_reg[wr_idx] <= wdata & STD_REG_WMASK;
    end
  end

  // one extended-low word per filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        filter_ext_id_low_reg[i] <= DATA_RESET;
      end
    end else if (wr_flt_ext) begin
      filter_ext_id_low_reg[wr_idx] <= wdata;
    end
  end

  // mask standard-id words; unimplemented bits never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_MASKS; i++) begin
        mask_std_id_and_type_mode_reg[i] <= DATA_RESET;
      end
    end else if (wr_msk_std) begin
      mask_std_id_and_type_mode_reg[wr_midx] <=
        wdata & STD_REG_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_MASKS; i++) begin
        mask_ext_id_low_reg[i] <= DATA_RESET;
      end
    end else if (wr_msk_ext) begin
      mask_ext_id_low_reg[wr_midx] <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filter_mask_select_0_7_reg <= SEL_RESET;
    end else if (wr_sel_lo) begin
      filter_mask_select_0_7_reg <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filter_mask_select_8_15_reg <= SEL_RESET;
    end else if (wr_sel_hi) begin
      filter_mask_select_8_15_reg <= wdata;
    end
  end

  // filters start disabled until software has loaded them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= ENABLE_RESET;
    end else if (wr_enable) begin
      enable_reg <= wdata;
    end
  end

  // ---------------- matching ----------------

  assign sel_all = {filter_mask_select_8_15_reg, filter_mask_select_0_7_reg};

  for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_flt
    cafm_sel_t sel;
    logic [1:0] midx;
    logic [STD_W-1:0] m_std;
    logic [EXT_W-1:0] m_ext;
    logic m_mode;

    assign sel = cafm_sel_t'(sel_all[2*f +: 2]);
    assign midx = sel;

    // selector 11 compares every bit and checks the frame type
    always_comb begin
      if (sel == CAFM_SEL_NONE) begin
        m_std = '1;
        m_ext = '1;
        m_mode = 1'b1;
      end else begin
        m_std = mask_std_id_and_type_mode_reg[midx][STD_MSB:STD_LSB];
        m_ext = {mask_std_id_and_type_mode_reg[midx][EXT_HI_MSB:0],
                 mask_ext_id_low_reg[midx]};
        m_mode = mask_std_id_and_type_mode_reg[midx][TYPE_BIT];
      end
    end

    cafm_filter_cmp u_cmp (
      .flt_std(flt_std_reg[f][STD_MSB:STD_LSB]),
      .flt_ext({flt_std_reg[f][EXT_HI_MSB:0],
                filter_ext_id_low_reg[f]}),
      .flt_ext_enable(flt_std_reg[f][TYPE_BIT]),
      .msk_std(m_std),
      .msk_ext(m_ext),
      .type_match_mode(m_mode),
      .msg_std(rx_std_id),
      .msg_ext(rx_ext_id),
      .msg_ide(rx_ide),
      .hit(hits[f])
    );
  end

  assign hits_en = hits & enable_reg;
  assign rx_take = ce && rx_id_valid;
  assign hit_seen = rx_take && pick_any;

  cafm_hit_pick u_pick (
    .hits(hits_en),
    .any(pick_any),
    .index(pick_idx)
  );

  // ---------------- result ----------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_valid <= 1'b0;
    end else if (ce) begin
      match_valid <= rx_id_valid;
    end
  end

  // result stands until the next identifier arrives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_hit <= 1'b0;
      match_index <= '0;
      match_vector <= '0;
    end else if (rx_take) begin
      match_hit <= pick_any;
      match_index <= pick_idx;
      match_vector <= hits_en;
    end
  end

  // saturating hit count; any write to it restarts it,
  // and a hit in that same cycle is still counted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_cnt_reg <= DATA_RESET;
    end else if (ce) begin
      if (wr_hit_cnt) begin
        hit_cnt_reg <= REG_W'(hit_seen);
      end else if (hit_seen && hit_cnt_reg != '1) begin
        hit_cnt_reg <= hit_cnt_reg + 16'h0001;
      end
    end
  end

endmodule : cafm_top

// ===== sim/cafm_checker.sv
// checker: port-level properties of the acceptance filter block
`timescale 1ns/1ps
module cafm_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_id_valid,
  input wire logic match_valid,
  input wire logic match_hit,
  input wire logic [3:0] match_index,
  input wire logic [15:0] match_vector
);
  logic take;
  assign take = hsel & hready & htrans[1] & ce;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_match_latency: assert property (rx_id_valid && ce |=> match_valid)
    else $error("no match report one cycle after an id");
  a_no_stray_valid: assert property (match_valid |->
    $past(rx_id_valid) || !$past(ce))
    else $error("match report without an id");
  a_hit_is_any: assert property (match_valid |-> match_hit == |match_vector)
    else $error("hit flag disagrees with hit vector");
  a_index_lowest: assert property (match_valid && match_hit |->
    match_vector[match_index] && ((match_vector &
    ((16'h0001 << match_index) - 16'h0001)) == 16'h0000))
    else $error("index is not the lowest hitting filter");
  a_miss_clean: assert property (match_valid && !match_hit |->
    match_index == 4'h0 && match_vector == 16'h0000)
    else $error("miss leaves index or vector set");
  a_result_hold: assert property (!match_valid |->
    $stable(match_vector) && $stable(match_index))
    else $error("results moved without a new id");
  a_read_wait: assert property (take && !hwrite |=>
    !hreadyout ##1 (hreadyout || !ce || !$past(ce)))
    else $error("read answer timing wrong");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout || !ce)
    else $error("write data phase stalled");
  a_rdata_width: assert property (hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  c_hit: cover property (match_valid && match_hit);
  c_miss: cover property (match_valid && !match_hit);
  c_read: cover property (take && !hwrite);
  c_stall: cover property (rx_id_valid && !ce);
endmodule : cafm_checker

bind cafm_top cafm_checker u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .rx_id_valid(rx_id_valid), .match_valid(match_valid),
  .match_hit(match_hit), .match_index(match_index),
  .match_vector(match_vector));

// ===== sim/cafm_rx_src.sv
// far-side model: receive path handing identifiers to the filter
`timescale 1ns/1ps
module cafm_rx_src (
  input wire logic hclk,
  output logic rx_id_valid,
  output logic [10:0] rx_std_id,
  output logic [17:0] rx_ext_id,
  output logic rx_ide
);
  initial begin
    rx_id_valid = 1'b0;
    rx_std_id = 11'h0;
    rx_ext_id = 18'h0;
    rx_ide = 1'b0;
  end
  // ids are inverted after the pulse so stale values cannot fake a hit
  task automatic send(input logic [10:0] s, input logic [17:0] e,
      input logic x);
    rx_id_valid <= 1'b1;
    rx_std_id <= s;
    rx_ext_id <= e;
    rx_ide <= x;
    @(posedge hclk);
    rx_id_valid <= 1'b0;
    rx_std_id <= ~s;
    rx_ext_id <= ~e;
    rx_ide <= ~x;
  endtask : send
endmodule : cafm_rx_src

// ===== sim/cafm_top_tb_top.sv
// self-checking bench for the acceptance filter block
`timescale 1ns/1ps
module cafm_top_tb_top;
  import cafm_pkg::*;
  localparam logic [10:0] S = 11'h5A3;
  localparam logic [17:0] E = 18'h2C35A;
  localparam logic [15:0] FSW = {S, 3'b010, E[17:16]};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rx_id_valid, rx_ide, match_valid, match_hit;
  logic [10:0] rx_std_id;
  logic [17:0] rx_ext_id;
  logic [3:0] match_index;
  logic [15:0] match_vector;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  cafm_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_id_valid(rx_id_valid),
    .rx_std_id(rx_std_id), .rx_ext_id(rx_ext_id), .rx_ide(rx_ide),
    .match_valid(match_valid), .match_hit(match_hit),
    .match_index(match_index), .match_vector(match_vector));
  cafm_rx_src u_src (.hclk(hclk), .rx_id_valid(rx_id_valid),
    .rx_std_id(rx_std_id), .rx_ext_id(rx_ext_id), .rx_ide(rx_ide));
  always #2.5 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // iff samples hready before this edge's own updates land
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    @(posedge hclk iff hreadyout === 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    @(posedge hclk iff hreadyout === 1'b1);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    @(posedge hclk iff hreadyout === 1'b1);
    htrans <= 2'h0;
    @(posedge hclk iff hreadyout === 1'b1);
    chk(hrdata, {16'h0, exp});
  endtask : rdc
  task automatic rx(input logic [10:0] s, input logic [17:0] e,
      input logic x, input logic h, input logic [3:0] i);
    u_src.send(s, e, x);
    #1;
    chk({31'h0, match_valid}, 32'h1);
    chk({31'h0, match_hit}, {31'h0, h});
    if (h)
      chk({28'h0, match_index}, {28'h0, i});
    @(posedge hclk);
  endtask : rx
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(SEL_LO_OFS, 16'h0000);
    rdc(8'hBC, 16'h0000);
    wr(MSK_STD_BASE, 16'hFFFF);
    rdc(MSK_STD_BASE, 16'hFFEB);
    wr(FLT_EXT_BASE + 8'h3C, 16'hA5C3);
    rdc(FLT_EXT_BASE + 8'h3C, 16'hA5C3);
    wr(FLT_STD_BASE, FSW);
    wr(FLT_EXT_BASE, E[15:0]);
    rdc(FLT_STD_BASE, FSW);
    wr(ENABLE_OFS, 16'h0001);
    wr(SEL_LO_OFS, 16'h0003);
    rx(S, E, 1'b1, 1'b1, 4'h0);
    rx(S, E ^ 18'h00001, 1'b1, 1'b0, 4'h0);
    rx(S, E ^ 18'h10000, 1'b1, 1'b0, 4'h0);
    rx(S ^ 11'h400, E, 1'b1, 1'b0, 4'h0);
    for (int m = 0; m < 3; m++) begin
      wr(MSK_STD_BASE + 8'(4 * m), m == 1 ? 16'hFFE0 : 16'h0000);
      wr(MSK_EXT_BASE + 8'(4 * m), m == 1 ? 16'h00FF : 16'h0000);
    end
    wr(SEL_LO_OFS, 16'h0001);
    rx(S, E ^ 18'h3FF00, 1'b1, 1'b1, 4'h0);
    rx(S, E ^ 18'h00080, 1'b1, 1'b0, 4'h0);
    rx(S ^ 11'h001, E, 1'b1, 1'b0, 4'h0);
    rx(S, E, 1'b0, 1'b1, 4'h0);
    wr(MSK_STD_BASE + 8'h04, 16'hFFE8);
    rx(S, E, 1'b0, 1'b0, 4'h0);
    rx(S, E, 1'b1, 1'b1, 4'h0);
    for (int c = 0; c < 4; c++) begin
      wr(SEL_LO_OFS, 16'(c));
      rx(S ^ 11'h001, E, 1'b1, c[0] == 1'b0, 4'h0);
    end
    wr(FLT_STD_BASE + 8'h1C, FSW);
    wr(FLT_EXT_BASE + 8'h1C, E[15:0]);
    wr(ENABLE_OFS, 16'h0080);
    wr(SEL_LO_OFS, 16'hC000);
    rx(S ^ 11'h001, E, 1'b1, 1'b0, 4'h0);
    wr(SEL_LO_OFS, 16'h3FFF);
    rx(S ^ 11'h001, E, 1'b1, 1'b1, 4'h7);
    wr(HIT_CNT_OFS, 16'h0000);
    wr(ENABLE_OFS, 16'h8081);
    wr(SEL_HI_OFS, 16'hC000);
    rx(S, E, 1'b1, 1'b1, 4'h0);
    rdc(HITS_OFS, 16'h0081);
    rdc(STATUS_OFS, 16'h0010);
    // an id offered while frozen must be neither reported nor counted
    ce <= 1'b0;
    u_src.send(S, E, 1'b1);
    #1;
    chk({30'h0, match_valid, hreadyout}, 32'h0);
    @(posedge hclk);
    ce <= 1'b1;
    wr(SEL_LO_OFS, 16'hFFFF);
    rx(11'h000, 18'h00000, 1'b0, 1'b1, 4'hF);
    rx(11'h001, 18'h00000, 1'b0, 1'b0, 4'h0);
    rdc(HIT_CNT_OFS, 16'h0002);
    end_of_test();
  end
endmodule : cafm_top_tb_top
